/* bench/irq_status_props.sv */
/* Checker on the collector ports: readback, wake, interrupt lines.
   Assumes the bind below onto irq_status_collector. */
`timescale 1ns/10ps
module irq_status_props (
  // Clock and reset
  input logic sys_clk_i, nrst_i,
  // Register bus
  input logic [7:0] avs_address_i,
  input logic avs_read_i, avs_write_i, avs_waitrequest_o,
  input logic [31:0] avs_readdata_o,
  // Sources and outputs
  input logic rx_halted_i, transceiver_event_i,
  input logic master_irq_o, power_irq_o, asleep_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  wire ans = !avs_waitrequest_o && avs_read_i;
  wire rd58 = ans && avs_address_i == 8'h58;
  wire wake = !avs_waitrequest_o && avs_write_i && avs_address_i == 8'h64;
  ////////////////////////////////////////////////////////////////////
  chk_reserved_zero: assert property (
    rd58 |-> (avs_readdata_o & 32'h7C40_1000) == 0) else $error("reserved");
  chk_byte_test: assert property (
    ans && avs_address_i == 8'h64 |-> avs_readdata_o == 32'h8765_4321)
    else $error("byte test");
  chk_unmapped_zero: assert property (
    ans && avs_address_i == 8'h70 |-> avs_readdata_o == 0) else $error("hole");
  chk_wake_write: assert property (
    wake |=> !asleep_o) else $error("no wake");
  chk_stay_asleep: assert property (
    asleep_o && !wake |=> asleep_o) else $error("self wake");
  chk_halt_level: assert property (
    rd58 && $past(rx_halted_i, 2) && $past(rx_halted_i, 3)
    |-> avs_readdata_o[24]) else $error("halt bit");
  chk_xcvr_mirror: assert property (
    rd58 && !$past(transceiver_event_i) |-> !avs_readdata_o[18])
    else $error("xcvr bit");
  chk_xcvr_live: assert property (
    rd58 && $past(transceiver_event_i) |-> avs_readdata_o[18])
    else $error("xcvr live");
  chk_pwr_master: assert property (
    power_irq_o |-> master_irq_o) else $error("pwr alone");
  cover property (rd58 && avs_readdata_o != 0);
  cover property (wake);
  cover property ($rose(power_irq_o));
endmodule
bind irq_status_collector irq_status_props u_props (.sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_readdata_o(avs_readdata_o), .rx_halted_i(rx_halted_i),
  .transceiver_event_i(transceiver_event_i), .master_irq_o(master_irq_o),
  .power_irq_o(power_irq_o), .asleep_o(asleep_o));

/* bench/tb.sv */
/* Bench for the collector: bus tasks, source pulses, status checks.
   Assumes the design and checker files are compiled before it. */
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, wt, mi, pi, sl;
  logic [7:0] adr = 0, fbk = 0;
  logic [3:0] be = 4'hF;
  event finished;
  logic [11:0] fb = 12'd2049;
  logic [15:0] tm = 16'h1234;
  logic [31:0] wd = 0, s = 0, dc = 0, rdat, p;
  int num_errors = 0, samples_checked = 0;
  int bl[19] = '{0,1,2,3,4,5,6,7,8,10,11,13,14,15,16,20,21,24,25};
  irq_status_collector DUT (.sys_clk_i(clk), .nrst_i(rst_n),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .tx_stop_requested_i(s[25]),
    .tx_halted_i(s[26]), .rx_halted_i(s[24]), .rx_drop_count_i(dc),
    .tx_buffer_loaded_i(s[21]), .completion_notify_flag_i(s[22]),
    .rx_dma_count_done_i(s[20]), .timer_count_i(tm),
    .transceiver_event_i(s[18]), .power_event_detected_i(s[17]),
    .tx_status_overflow_i(s[16]), .rx_frame_end_i(s[15]),
    .rx_frame_bytes_i(fb), .receiver_error_i(s[14]),
    .transmitter_error_i(s[13]), .tx_data_underrun_i(s[11]),
    .tx_data_full_i(s[12]), .tx_data_write_i(s[10]), .tx_free_blocks_i(fbk),
    .tx_status_full_i(s[8]), .tx_status_level_i(s[7]),
    .frame_dropped_i(s[6]), .rx_data_level_i(s[5]), .rx_status_full_i(s[4]),
    .rx_status_level_i(s[3]), .pin_event_i(s[2:0]), .master_irq_o(mi),
    .power_irq_o(pi), .asleep_o(sl));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) num_errors++;
    if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
  endtask
  // Request held until waitrequest is seen low, released after
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    int n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wt !== 1'b0 && ++n < 20);
    if (n >= 20) begin
      num_errors++;
      -> finished;
      disable tests;
    end
    if (!w) chk($sformatf("reg %h", a), e, rdat);
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  // Pins pass a synchroniser, so allow settling time
  task automatic pulse(logic [31:0] v);
    s <= v;
    @(posedge clk);
    s <= 0;
    repeat (6) @(posedge clk);
  endtask
  task automatic clr(logic [31:0] m);
    bus(1, 8'h58, 0, 0);
    bus(0, 8'h58, 0, m);
    bus(1, 8'h58, m, 0);
    bus(0, 8'h58, 0, 0);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    @(finished);
    complete_run();
  end
  initial begin : tests
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    bus(0, 8'h58, 0, 0);
    bus(0, 8'h64, 0, 32'h8765_4321);
    bus(0, 8'h70, 0, 0);
    foreach (bl[i]) begin
      p = 32'h1 << bl[i];
      if (bl[i] == 21 || bl[i] == 25) p = p | p << 1;
      if (bl[i] == 10) p = p | 32'h0000_1000;
      pulse(p);
      clr(32'h1 << bl[i]);
    end
    chk("masked irq", 0, mi);
    tm <= 16'h0000;
    @(posedge clk);
    tm <= 16'hFFFF;
    dc <= 32'h7FFF_FFFF;
    @(posedge clk);
    dc <= 32'h8000_0000;
    pulse(0);
    clr(32'h0088_0000);
    bus(1, 8'h80, 32'h0000_0010, 0);
    fbk <= 8'h10;
    pulse(0);
    bus(0, 8'h58, 0, 0);
    fbk <= 8'h11;
    pulse(0);
    fbk <= 0;
    clr(32'h0000_0200);
    s <= 32'h0104_0000;
    repeat (4) @(posedge clk);
    bus(1, 8'h58, 32'h0004_0000, 0);
    bus(0, 8'h58, 0, 32'h0104_0000);
    pulse(0);
    clr(32'h0100_0000);
    bus(1, 8'h5C, 32'h8000_0000, 0);
    pulse(0);
    chk("sw irq", 1, mi);
    bus(1, 8'h5C, 0, 0);
    clr(32'h8000_0000);
    chk("irq off", 0, mi);
    bus(1, 8'h80, 32'h0000_0100, 0);
    bus(0, 8'h80, 0, 32'h0000_0100);
    bus(1, 8'h5C, 32'h4002_0000, 0);
    bus(0, 8'h5C, 0, 32'h0002_0000);
    pulse(32'h0002_0000);
    chk("power irq", 1, pi);
    bus(0, 8'h84, 0, 1);
    bus(1, 8'h64, 0, 0);
    bus(0, 8'h84, 0, 0);
    bus(1, 8'h5C, 0, 0);
    clr(32'h0002_0000);
    pulse(32'h0100_0008);
    be <= 4'h1;
    bus(1, 8'h58, 32'h0100_0008, 0);
    be <= 4'hF;
    bus(0, 8'h58, 0, 32'h0100_0000);
    clr(32'h0100_0000);
    -> finished;
  end
endmodule

/* logic/irq_status_collector.v */
/*
  Interrupt status collector: sticky event status word, enable mask,
  master interrupt line, power event interrupt line and sleep latch, on Avalon-MM.
  Registers: status at 58h, enable at 5Ch, byte order test at 64h,
  source control at 80h, wake state at 84h.
  Assumes event inputs are one-cycle pulses or levels synchronous to
  sys_clk_i; pin events arrive asynchronous and are synchronised here.
  Assumes a master that holds each request until waitrequest is seen
  low, one access at a time; byteenable gates the clearing bytes.
  Assumes the timer idles at FFFFh after reset, so a wrap needs a
  fresh zero first.
*/
// What this block does
// - Writing one to a status bit clears it.
// - Bit 31 sets while the software raise enable is high.
// - Bit 25 sets when stop is requested and transmitter halted.
// - Bit 24 sets when the receiver halts.
// - Bit 23 sets when drop counter steps to 80000000h.
// - Bit 21 sets when a completion-flagged buffer is loaded.
// - Bit 20 sets when the receive DMA count has been moved.
// - Bit 19 sets when the timer wraps from zero to FFFFh.
// - Bit 18 mirrors the transceiver event; writes ignored.
// - Bit 17 sets on power events, independent of the pin enable.
// - Only a write to the byte order register wakes the device.
// - Power event interrupt bypasses the deassertion hold-off.
// - Bit 16 sets on transmit status FIFO overflow.
// - Bit 15 sets on a received packet over 2048 bytes.
// - Bit 14 on receiver error, bit 13 on transmitter error.
// - Bit 11 sets on transmit data FIFO underrun.
// - Bit 10 sets on a write into a full transmit data FIFO.
// - Bit 9 sets when free transmit space exceeds its threshold.
// - Bit 8 on transmit status full, bit 4 on receive status full.
// - Bits 7, 5, 3 set at their FIFO threshold levels.
// - Bit 6 sets each time a received frame is dropped.
// - Bits 2..0 capture configured pin events.
// - Status records events whether enabled or not.
// - Master interrupt is OR of enabled pending bits.
`timescale 1ns/10ps
`include "irq_status_map.vh"

module irq_status_collector (
  // Clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // Avalon-MM slave
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Synchronous event sources
  input wire tx_stop_requested_i,
  input wire tx_halted_i,
  input wire rx_halted_i,
  input wire [31:0] rx_drop_count_i,
  input wire tx_buffer_loaded_i,
  input wire completion_notify_flag_i,
  input wire rx_dma_count_done_i,
  input wire [15:0] timer_count_i,
  input wire transceiver_event_i,
  input wire power_event_detected_i,
  input wire tx_status_overflow_i,
  input wire rx_frame_end_i,
  input wire [11:0] rx_frame_bytes_i,
  input wire receiver_error_i,
  input wire transmitter_error_i,
  input wire tx_data_underrun_i,
  input wire tx_data_full_i,
  input wire tx_data_write_i,
  input wire [7:0] tx_free_blocks_i,
  input wire tx_status_full_i,
  input wire tx_status_level_i,
  input wire frame_dropped_i,
  input wire rx_data_level_i,
  input wire rx_status_full_i,
  input wire rx_status_level_i,
  // Pin events, asynchronous
  input wire [2:0] pin_event_i,
  // Interrupt and power outputs
  output reg master_irq_o,
  output reg power_irq_o,
  output reg asleep_o
);

////////////////////////////////////////////////////////////////////////
// Registers

reg [31:0] interrupt_event_status;
reg [31:0] interrupt_enable;
reg [7:0] space_threshold;
reg sleep_req;
reg [15:0] timer_prev;
reg [31:0] drop_prev;
reg [2:0] pin_meta;
reg [2:0] pin_sync;
reg [2:0] pin_prev;
reg [1:0] bus_state;
reg [1:0] next_bus_state;
reg [31:0] read_mux;

reg [31:0] next_status;
reg [31:0] events;
wire [31:0] status_view;
wire wr_status;
wire [31:0] clear_mask;
wire software_raise_enable;
wire busy;
wire request;
wire hit_status;
wire hit_enable;
wire hit_byte_order;
wire hit_source_ctrl;
wire hit_wake_state;
wire take_write;
wire first_read;
wire wake_write;
wire sleep_write;

////////////////////////////////////////////////////////////////////////
// Bus decode

// Handshake states, one-hot
localparam [1:0] BUS_IDLE = 2'h1;
localparam [1:0] BUS_ANSWER = 2'h2;

assign busy = bus_state[1];
assign request = avs_read_i | avs_write_i;
// Address matches
assign hit_status = avs_address_i == `OFS_INT_STATUS;
assign hit_enable = avs_address_i == `OFS_INT_ENABLE;
assign hit_byte_order = avs_address_i == `OFS_BYTE_ORDER;
assign hit_source_ctrl = avs_address_i == `OFS_SOURCE_CTRL;
assign hit_wake_state = avs_address_i == `OFS_WAKE_STATE;

// Writes land on the edge where waitrequest is seen low
assign take_write = avs_write_i & busy;
assign wr_status = take_write & hit_status;
assign wake_write = take_write & hit_byte_order;
assign sleep_write = take_write & hit_source_ctrl & avs_writedata_i[8];
// Reads fetch one edge early so the data stand when taken
assign first_read = avs_read_i & ~busy;
// Status write clears only the enabled bytes
assign clear_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}} & avs_writedata_i;
assign software_raise_enable = interrupt_enable[`BIT_SW];

////////////////////////////////////////////////////////////////////////
// Handshake state machine

// One wait state, then one answer cycle; no back-to-back answer
always @* begin
  next_bus_state = bus_state;
  case (bus_state)
    BUS_IDLE: begin
      if (request) begin
        next_bus_state = BUS_ANSWER;
      end
    end
    BUS_ANSWER: begin
      next_bus_state = BUS_IDLE;
    end
    default: begin
      // Illegal one-hot code falls back to idle
      next_bus_state = BUS_IDLE;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////
// Read decode

// Status reads show the live transceiver level
always @* begin
  if (hit_status) begin
    read_mux = status_view;
  end else if (hit_enable) begin
    read_mux = interrupt_enable;
  end else if (hit_byte_order) begin
    read_mux = `BYTE_ORDER_VALUE;
  end else if (hit_source_ctrl) begin
    read_mux = {23'h00_0000, sleep_req, space_threshold};
  end else if (hit_wake_state) begin
    read_mux = {31'h0000_0000, asleep_o};
  end else begin
    read_mux = `UNMAPPED_READ;
  end
end

// Transceiver bit is a live reflection, not a latch
assign status_view = (interrupt_event_status & ~(32'h0000_0001 << `BIT_XCVR))
  | ({31'h0000_0000, transceiver_event_i} << `BIT_XCVR);

////////////////////////////////////////////////////////////////////////
// Pin event synchronisers, rising edge per pin

genvar g;
generate
  for (g = 0; g < 3; g = g + 1) begin : pin_sync_g
    always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pin_meta[g] <= 1'b0;
        pin_sync[g] <= 1'b0;
        pin_prev[g] <= 1'b0;
      end else begin
        pin_meta[g] <= pin_event_i[g];
        pin_sync[g] <= pin_meta[g];
        pin_prev[g] <= pin_sync[g];
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// Event collection

always @* begin
  events = 32'h0000_0000;
  events[`BIT_SW] = software_raise_enable;
  events[`BIT_TX_HALT] = tx_stop_requested_i & tx_halted_i;
  events[`BIT_RX_HALT] = rx_halted_i;
  events[`BIT_DROP_MID] = (rx_drop_count_i == `DROP_MID_VALUE) &
    (drop_prev != `DROP_MID_VALUE);
  events[`BIT_TX_DONE] = tx_buffer_loaded_i &
    completion_notify_flag_i;
  events[`BIT_RX_DMA] = rx_dma_count_done_i;
  events[`BIT_TIMER] = (timer_count_i == `TIMER_WRAP_VALUE) &
    (timer_prev == 16'h0000);
  events[`BIT_PWR] = power_event_detected_i;
  events[`BIT_TXS_OVF] = tx_status_overflow_i;
  events[`BIT_RX_OVERSIZE] = rx_frame_end_i &
    (rx_frame_bytes_i > `RX_OVERSIZE_BYTES);
  events[`BIT_RX_ERR] = receiver_error_i;
  events[`BIT_TX_ERR] = transmitter_error_i;
  events[`BIT_TXD_UNDER] = tx_data_underrun_i;
  events[`BIT_TXD_OVER] = tx_data_full_i & tx_data_write_i;
  events[`BIT_TXD_SPACE] = tx_free_blocks_i > space_threshold;
  events[`BIT_TXS_FULL] = tx_status_full_i;
  events[`BIT_RXS_FULL] = rx_status_full_i;
  events[`BIT_TXS_LEVEL] = tx_status_level_i;
  events[`BIT_RXD_LEVEL] = rx_data_level_i;
  events[`BIT_RXS_LEVEL] = rx_status_level_i;
  events[`BIT_RX_DROP] = frame_dropped_i;
  events[2:0] = pin_sync & ~pin_prev;
end

// Set wins over a clear in the same cycle; no enable gating here
always @* begin
  next_status = interrupt_event_status;
  if (wr_status) begin
    next_status = next_status & ~clear_mask;
  end
  next_status = (next_status | events) & `STATUS_MASK;
end

////////////////////////////////////////////////////////////////////////
// Handshake registers

always @(posedge sys_clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    bus_state <= BUS_IDLE;
    avs_waitrequest_o <= 1'b1;
  end else begin
    bus_state <= next_bus_state;
    // Low for exactly the answer cycle
    avs_waitrequest_o <= ~next_bus_state[1];
  end
end

// Read data hold until the next read request, which fetches one edge before it is taken
always @(posedge sys_clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    avs_readdata_o <= `READDATA_RESET;
  end else if (first_read) begin
    avs_readdata_o <= read_mux;
  end
end

////////////////////////////////////////////////////////////////////////
// Status word and edge history

always @(posedge sys_clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    interrupt_event_status <= `STATUS_RESET;
    // Idle timer value, so reset alone is no wrap
    timer_prev <= `TIMER_PREV_RESET;
    drop_prev <= `DROP_PREV_RESET;
  end else begin
    interrupt_event_status <= next_status;
    timer_prev <= timer_count_i;
    drop_prev <= rx_drop_count_i;
  end
end

////////////////////////////////////////////////////////////////////////
// Enable mask and source control

always @(posedge sys_clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    interrupt_enable <= `ENABLE_RESET;
    space_threshold <= `THRESHOLD_RESET;
  end else if (take_write) begin
    if (hit_enable) begin
      // Reserved enable bits stay zero
      interrupt_enable <= avs_writedata_i & `STATUS_MASK;
    end else if (hit_source_ctrl) begin
      space_threshold <= avs_writedata_i[7:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Sleep latch

// No power event input reaches this latch
always @(posedge sys_clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    sleep_req <= 1'b0;
  end else if (wake_write) begin
    sleep_req <= 1'b0;
  end else if (sleep_write) begin
    sleep_req <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// Interrupt and power outputs

always @(posedge sys_clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    master_irq_o <= 1'b0;
    power_irq_o <= 1'b0;
    asleep_o <= 1'b0;
  end else begin
    // Only the byte order write wakes; power events never do
    asleep_o <= sleep_req & ~wake_write;
    master_irq_o <= |(status_view & interrupt_enable);
    // Straight path, no hold-off interval
    power_irq_o <= interrupt_event_status[`BIT_PWR] &
      interrupt_enable[`BIT_PWR];
  end
end

endmodule

/* logic/irq_status_map.vh */
/*
  Register offsets, field positions, reset values and the event match
  constants of the interrupt status collector.
  Assumes inclusion by bare name from the design file.
*/
`ifndef IRQ_STATUS_MAP_VH
`define IRQ_STATUS_MAP_VH

// Byte addresses on the register bus
`define OFS_INT_STATUS    8'h58
`define OFS_INT_ENABLE    8'h5C
`define OFS_BYTE_ORDER    8'h64
`define OFS_SOURCE_CTRL   8'h80
`define OFS_WAKE_STATE    8'h84

// Status bit positions
`define BIT_SW            31
`define BIT_TX_HALT       25
`define BIT_RX_HALT       24
`define BIT_DROP_MID      23
`define BIT_TX_DONE       21
`define BIT_RX_DMA        20
`define BIT_TIMER         19
`define BIT_XCVR          18
`define BIT_PWR           17
`define BIT_TXS_OVF       16
`define BIT_RX_OVERSIZE   15
`define BIT_RX_ERR        14
`define BIT_TX_ERR        13
`define BIT_TXD_UNDER     11
`define BIT_TXD_OVER      10
`define BIT_TXD_SPACE     9
`define BIT_TXS_FULL      8
`define BIT_TXS_LEVEL     7
`define BIT_RX_DROP       6
`define BIT_RXD_LEVEL     5
`define BIT_RXS_FULL      4
`define BIT_RXS_LEVEL     3

// Implemented status bits; 30..26, 22 and 12 are reserved
`define STATUS_MASK       32'h83BF_EFFF
`define STATUS_RESET      32'h0000_0000
`define ENABLE_RESET      32'h0000_0000
`define BYTE_ORDER_VALUE  32'h8765_4321
`define DROP_MID_VALUE    32'h8000_0000
`define TIMER_WRAP_VALUE  16'hFFFF
`define RX_OVERSIZE_BYTES 12'h800
`define UNMAPPED_READ     32'h0000_0000
`define THRESHOLD_RESET 8'h00
`define TIMER_PREV_RESET 16'hFFFF
`define DROP_PREV_RESET 32'h0000_0000
`define READDATA_RESET 32'h0000_0000

`endif
